// ### logic/ldsr_defs.vh
// constants for the lock detector status readout: command codes, pin addresses, status bits
// assumes inclusion by bare name from the load tracker and top-level design files of the block
`ifndef LDSR_DEFS_VH
`define LDSR_DEFS_VH
`define LDSR_CMD_HALT       5'h18
`define LDSR_CMD_RESTART    5'h19
`define LDSR_CMD_INIT       5'h1e
`define LDSR_CMD_CLAG_LOAD  5'h0d
`define LDSR_CMD_SLAG_LOAD  5'h13
`define LDSR_RDSEL_LOCKDET  5'h03
`define LDSR_PIN_WRADDR     3'h4
`define LDSR_PIN_RDADDR     3'h5
`define LDSR_PIN_STATUS     3'h4
`define LDSR_PIN_PE_HI      3'h3
`define LDSR_PIN_PE_LO      3'h2
`define LDSR_PIN_FL_HI      3'h1
`define LDSR_PIN_FL_LO      3'h0
`define LDSR_SB_SM_READY    7
`define LDSR_SB_UP_READY    6
`define LDSR_SB_CLAG_DONE   5
`define LDSR_SB_SLAG_DONE   4
`define LDSR_SB_LOCK        3
`define LDSR_SB_ACQ         2
`define LDSR_SB_SWEEP_DN    0
`define LDSR_INT_LEN        16'h0400
`define LDSR_LOAD_CYCLES    4'h8
`endif

// ### logic/ldsr_sync.v
// three-stage synchroniser for an asynchronous pin with agreement filter
// assumes the pin is unrelated to clk; output changes once stages two and three agree
`timescale 1ns/1ps
module ldsr_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] pin,
  output reg  [WIDTH-1:0] level
);
  reg [WIDTH-1:0] s1;
  reg [WIDTH-1:0] s2;
  reg [WIDTH-1:0] s3;
  genvar i;
  always @(posedge clk) begin
    if (!resetn) begin
      s1 <= {WIDTH{1'b0}};
      s2 <= {WIDTH{1'b0}};
      s3 <= {WIDTH{1'b0}};
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (!resetn) begin
          level[i] <= 1'b0;
        end else if (s2[i] == s3[i]) begin
          level[i] <= s3[i];
        end
      end
    end
  endgenerate
endmodule // ldsr_sync

// ### logic/ldsr_load.v
// lag accumulator load tracker: a 32-bit load runs a fixed number of cycles after its command
// assumes start is a one-cycle pulse on clk
`timescale 1ns/1ps
`include "ldsr_defs.vh"
module ldsr_load (
  input  wire clk,
  input  wire resetn,
  input  wire start,
  output reg  done
);
  reg [3:0] cnt;
  always @(posedge clk) begin
    if (!resetn) begin
      cnt  <= 4'h0;
      done <= 1'b1;
    end else if (start) begin
      cnt  <= `LDSR_LOAD_CYCLES;
      done <= 1'b0;
    end else if (cnt != 4'h0) begin
      cnt  <= cnt - 4'h1;
      done <= (cnt == 4'h1);
    end
  end
endmodule // ldsr_load

// ### logic/ldsr_top.v
// lock detector status readout: host command decode, lock detector run control,
// accumulator snapshot byte readout and the internal status byte
// assumes host strobes are asynchronous, active low, and held several clocks
// Overview of operation
// - command 24 halts detector at end of current cycle, no counter reload
// - halting keeps verify count; restart resumes from it
// - read select 3: pins 3,2,1,0 give pe hi, pe lo, fl hi, fl lo
// - bit 7 ready in state machine mode, bit 6 in processor mode
// - command 30 clears accumulators and integration counter, processor mode only
// - command 25 restarts a halted detector
// - bit 5 carrier lag load complete; command 13 starts the load
// - bit 4 symbol lag load complete; command 19 starts the load
// - bit 3 shows carrier lock declared
// - bit 2 acquisition mode, 0 tracking; bit 1 reserved reads zero
// - bit 0 sweep direction, 0 up, 1 down
// - interrupt marks end of every accumulation cycle
// - status byte refreshed every clock
// - host address and strobes may be asynchronous to clk
// - status byte driven on data bus at pin address 100 with read
// - processor mode stops detector after every integration period
`timescale 1ns/1ps
`include "ldsr_defs.vh"
module ldsr_top #(
  parameter INT_LEN  = `LDSR_INT_LEN,
  parameter VER_BITS = 8
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire [2:0]  pin_address_bits,
  input  wire        wr_n,
  input  wire        rd_n,
  input  wire [7:0]  host_data_in,
  output reg  [7:0]  host_data_bus,
  output wire        host_data_oe,
  input  wire        up_mode,
  input  wire [15:0] phase_error_sample,
  input  wire [15:0] false_lock_sample,
  input  wire        lock_declared,
  input  wire        acq_mode,
  input  wire        sweep_down,
  output reg         lock_cycle_irq,
  output reg  [VER_BITS-1:0] verify_count
);
  localparam ST_RUN  = 3'b001;
  localparam ST_HALT = 3'b010;
  localparam ST_STOP = 3'b100;

  wire [2:0]  addr_s;
  wire        wr_s;
  wire        rd_s;
  wire [7:0]  din_s;
  reg         wr_d;
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [15:0] int_cnt;
  reg  [15:0] upper_word;
  reg  [15:0] lower_word;
  reg  [31:0] pe_sum;
  reg  [31:0] fl_sum;
  reg  [4:0]  read_sel;
  reg  [7:0]  status_bits;
  wire        wr_pulse;
  wire        cmd_halt;
  wire        cmd_restart;
  wire        cmd_init;
  wire        cycle_end;
  wire        clag_done;
  wire        slag_done;

  ldsr_sync #(.WIDTH(13)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .pin    ({pin_address_bits, ~wr_n, ~rd_n, host_data_in}),
    .level  ({addr_s, wr_s, rd_s, din_s})
  );

  always @(posedge clk) begin
    if (!resetn) begin
      wr_d <= 1'b0;
    end else begin
      wr_d <= wr_s;
    end
  end

  // commands are latched on the write's falling-edge-equivalent so data has settled
  assign wr_pulse    = wr_s & ~wr_d;
  wire   wr_cmd      = wr_pulse & (addr_s == `LDSR_PIN_WRADDR);
  assign cmd_halt    = wr_cmd & (din_s[4:0] == `LDSR_CMD_HALT);
  assign cmd_restart = wr_cmd & (din_s[4:0] == `LDSR_CMD_RESTART);
  assign cmd_init    = wr_cmd & (din_s[4:0] == `LDSR_CMD_INIT) & up_mode;
  assign cycle_end   = (state != ST_STOP) && (int_cnt == INT_LEN - 1);

  always @(posedge clk) begin
    if (!resetn) begin
      read_sel <= 5'h00;
    end else if (wr_pulse && addr_s == `LDSR_PIN_RDADDR) begin
      read_sel <= din_s[4:0];
    end
  end

  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (cycle_end && up_mode) begin
          next_state = ST_STOP;
        end else if (cmd_halt) begin
          next_state = cycle_end ? ST_STOP : ST_HALT;
        end
      end
      ST_HALT: begin
        if (cycle_end) begin
          next_state = ST_STOP;
        end
      end
      ST_STOP: begin
        if (cmd_restart) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
    if (cmd_init) begin
      next_state = ST_RUN;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      state        <= ST_RUN;
      int_cnt      <= 16'h0000;
      pe_sum       <= 32'h0000_0000;
      fl_sum       <= 32'h0000_0000;
      upper_word   <= 16'h0000;
      lower_word   <= 16'h0000;
      verify_count <= {VER_BITS{1'b0}};
      lock_cycle_irq <= 1'b0;
    end else begin
      state          <= next_state;
      lock_cycle_irq <= cycle_end;
      if (cmd_init) begin
        int_cnt <= 16'h0000;
        pe_sum  <= 32'h0000_0000;
        fl_sum  <= 32'h0000_0000;
      end else if (cycle_end) begin
        // counter is not reloaded into a new cycle when the detector stops
        int_cnt    <= 16'h0000;
        upper_word <= pe_sum[31:16];
        lower_word <= fl_sum[31:16];
        pe_sum     <= 32'h0000_0000;
        fl_sum     <= 32'h0000_0000;
        if (lock_declared) begin
          verify_count <= verify_count + {{(VER_BITS-1){1'b0}}, 1'b1};
        end
      end else if (state != ST_STOP) begin
        int_cnt <= int_cnt + 16'h0001;
        pe_sum  <= pe_sum + {16'h0000, phase_error_sample};
        fl_sum  <= fl_sum + {16'h0000, false_lock_sample};
      end
      // stopped: snapshot, sums and verify count all hold
    end
  end
  // snapshot words only change at cycle end, so bytes of a stopped read are coherent

  ldsr_load u_clag (
    .clk    (clk),
    .resetn (resetn),
    .start  (wr_cmd & (din_s[4:0] == `LDSR_CMD_CLAG_LOAD)),
    .done   (clag_done)
  );

  ldsr_load u_slag (
    .clk    (clk),
    .resetn (resetn),
    .start  (wr_cmd & (din_s[4:0] == `LDSR_CMD_SLAG_LOAD)),
    .done   (slag_done)
  );

  always @(posedge clk) begin
    if (!resetn) begin
      status_bits <= 8'h00;
    end else begin
      status_bits <= {(state == ST_STOP) & ~up_mode,
                      (state == ST_STOP) & up_mode,
                      clag_done,
                      slag_done,
                      lock_declared,
                      acq_mode,
                      1'b0,
                      sweep_down};
    end
  end
  // status refreshed every clock, so two reads can differ

  always @(posedge clk) begin
    if (!resetn) begin
      host_data_bus <= 8'h00;
    end else if (addr_s == `LDSR_PIN_STATUS) begin
      host_data_bus <= status_bits;
    end else if (read_sel == `LDSR_RDSEL_LOCKDET) begin
      case (addr_s)
        `LDSR_PIN_PE_HI: host_data_bus <= upper_word[15:8];
        `LDSR_PIN_PE_LO: host_data_bus <= upper_word[7:0];
        `LDSR_PIN_FL_HI: host_data_bus <= lower_word[15:8];
        `LDSR_PIN_FL_LO: host_data_bus <= lower_word[7:0];
        default:         host_data_bus <= 8'h00;
      endcase
    end else begin
      host_data_bus <= 8'h00;
    end
  end

  assign host_data_oe = rd_s;
endmodule // ldsr_top

// ### testbench/ldsr_sva.sv
// checker for ldsr_top: irq spacing, verify counter, read enable, status and snapshot bytes
// assumes the host keeps rd_n low for at least 8 clocks per read
`timescale 1ns/1ps
module ldsr_sva #(
  parameter INT_LEN  = 16,
  parameter VER_BITS = 8
) (
  input wire logic                clk,
  input wire logic                resetn,
  input wire logic [2:0]          pin_address_bits,
  input wire logic                rd_n,
  input wire logic [7:0]          host_data_bus,
  input wire logic                host_data_oe,
  input wire logic                up_mode,
  input wire logic                lock_declared,
  input wire logic                acq_mode,
  input wire logic                sweep_down,
  input wire logic                lock_cycle_irq,
  input wire logic [VER_BITS-1:0] verify_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  irq_gap_a: assert property (lock_cycle_irq |=> !lock_cycle_irq[*8])
    else $error("lock cycle irq pulses too close");
  verify_step_a: assert property ($changed(verify_count) |->
    verify_count == $past(verify_count) + 1'b1) else $error("verify count jumped");
  verify_when_a: assert property ($changed(verify_count) |->
    lock_cycle_irq || $past(lock_cycle_irq)) else $error("verify count moved mid cycle");
  oe_off_a: assert property (rd_n[*8] |-> !host_data_oe)
    else $error("data bus driven without read");
  oe_on_a: assert property (!rd_n[*8] |-> host_data_oe)
    else $error("data bus not driven during read");
  status_low_a: assert property ((pin_address_bits == 3'h4 && !rd_n &&
    $stable({lock_declared, acq_mode, sweep_down}))[*8] |->
    host_data_bus[3:0] == {lock_declared, acq_mode, 1'b0, sweep_down})
    else $error("status low bits wrong");
  ready_mode_a: assert property ((pin_address_bits == 3'h4 && !rd_n &&
    $stable(up_mode))[*8] |-> !(up_mode ? host_data_bus[7] : host_data_bus[6]))
    else $error("ready bit of other mode set");
  snap_hold_a: assert property ((pin_address_bits == 3'h3 && !rd_n &&
    !lock_cycle_irq)[*8] |-> $stable(host_data_bus)) else $error("snapshot byte moved");
  cover property (lock_cycle_irq && up_mode);
  cover property (host_data_bus[7] && pin_address_bits == 3'h4);
  cover property ($changed(verify_count));
endmodule // ldsr_sva
bind ldsr_top ldsr_sva #(.INT_LEN(INT_LEN), .VER_BITS(VER_BITS)) ldsr_sva_inst (.*);

// ### testbench/ldsr_host.sv
// host processor model: writes codes, reads bytes and polls the status byte
// assumes it is the only driver of the host strobes, changing them at falling edges
`timescale 1ns/1ps
module ldsr_host (
  input  wire       clk,
  input  wire [7:0] host_data_bus,
  output reg  [2:0] pin_address_bits,
  output reg        wr_n,
  output reg        rd_n,
  output reg  [7:0] host_data_in
);
  initial begin
    pin_address_bits = 3'h0;
    wr_n = 1'b1;
    rd_n = 1'b1;
    host_data_in = 8'h00;
  end
  task wr(input [2:0] a, input [7:0] d); begin
    @(negedge clk);
    pin_address_bits = a;
    host_data_in = d;
    wr_n = 1'b0;
    repeat (5) @(negedge clk);
    wr_n = 1'b1;
    repeat (5) @(negedge clk);
    // released bus: show the inverse so a stale code is never mistaken for a held one
    host_data_in = ~d;
  end endtask
  task rd(input [2:0] a, output [7:0] q); begin
    @(negedge clk);
    pin_address_bits = a;
    rd_n = 1'b0;
    repeat (8) @(negedge clk);
    q = host_data_bus;
    rd_n = 1'b1;
  end endtask
  task poll(input integer b, output ok);
    integer n;
    reg [7:0] q;
    begin
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n = n + 1) begin
      rd(3'h4, q);
      ok = q[b];
    end
  end endtask
endmodule // ldsr_host

// ### testbench/lock_detector_status_readout_tb.sv
// self-checking bench for ldsr_top with the host model on its processor port
// assumes a short integration length so each detector cycle is 16 clocks
`timescale 1ns/1ps
module lock_detector_status_readout_tb;
  localparam INT_LEN = 16;
  reg         clk, resetn, up_mode, lock_declared, acq_mode, sweep_down, ok;
  reg  [15:0] pe_s, fl_s, w;
  reg  [7:0]  q, v;
  reg  [2:0]  k;
  wire [2:0]  pin;
  wire        wr_n, rd_n, oe, irq;
  wire [7:0]  din, dbus, vcnt;
  integer     seed, bad_count, n_compared, i, t;
  ldsr_top #(.INT_LEN(INT_LEN)) ldsr_top_inst (.clk(clk), .resetn(resetn),
    .pin_address_bits(pin), .wr_n(wr_n), .rd_n(rd_n), .host_data_in(din),
    .host_data_bus(dbus), .host_data_oe(oe), .up_mode(up_mode), .phase_error_sample(pe_s),
    .false_lock_sample(fl_s), .lock_declared(lock_declared), .acq_mode(acq_mode),
    .sweep_down(sweep_down), .lock_cycle_irq(irq), .verify_count(vcnt));
  ldsr_host ldsr_host_inst (.clk(clk), .host_data_bus(dbus), .pin_address_bits(pin),
    .wr_n(wr_n), .rd_n(rd_n), .host_data_in(din));
  function [15:0] acc_word(input [15:0] s);
    // the closing count of each cycle adds no sample, so a cycle holds INT_LEN-1 samples
    acc_word = ({16'h0000, s} * (INT_LEN - 1)) >> 16;
  endfunction
  task chk(input [7:0] got, input [7:0] exp); begin
    n_compared = n_compared + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  end endtask
  task close_out; begin
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  end endtask
  task wait_irq; begin
    @(negedge clk);
    t = 1;
    while (irq !== 1'b1 && t < 200) begin
      @(negedge clk);
      t = t + 1;
    end
    chk({7'h00, irq}, 8'h01);
  end endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #50000;
    bad_count = bad_count + 1;
    close_out;
  end
  initial begin
    seed = 32'h11bf;
    bad_count = 0;
    n_compared = 0;
    {resetn, up_mode, lock_declared, acq_mode, sweep_down} = 5'h00;
    pe_s = 16'h0000;
    fl_s = 16'h0000;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    for (i = 0; i < 4; i = i + 1) begin
      {lock_declared, acq_mode, sweep_down} = $random(seed);
      pe_s = $random(seed);
      fl_s = $random(seed);
      ldsr_host_inst.rd(3'h4, q);
      chk({4'h0, q[3:0]}, {4'h0, lock_declared, acq_mode, 1'b0, sweep_down});
    end
    for (i = 0; i < 2; i = i + 1) begin
      ldsr_host_inst.wr(3'h4, i ? 8'h13 : 8'h0d);
      ldsr_host_inst.rd(3'h4, q);
      chk({7'h00, q[5-i]}, 8'h01);
    end
    lock_declared = 1'b1;
    k = $random(seed);
    pe_s = {1'b0, k, 12'h000};
    k = $random(seed);
    fl_s = {1'b0, k, 12'h000};
    // two cycle ends so the halted cycle saw only the held samples
    wait_irq;
    wait_irq;
    ldsr_host_inst.wr(3'h4, 8'h18);
    ldsr_host_inst.poll(7, ok);
    chk({7'h00, ok}, 8'h01);
    v = vcnt;
    ldsr_host_inst.wr(3'h4, 8'h1e);
    ldsr_host_inst.wr(3'h5, 8'h03);
    for (i = 3; i >= 0; i = i - 1) begin
      w = (i > 1) ? acc_word(pe_s) : acc_word(fl_s);
      ldsr_host_inst.rd(i[2:0], q);
      chk(q, i[0] ? w[15:8] : w[7:0]);
    end
    chk(vcnt, v);
    ldsr_host_inst.wr(3'h4, 8'h19);
    wait_irq;
    @(negedge clk);
    chk(vcnt, v + 8'h01);
    up_mode = 1'b1;
    wait_irq;
    t = 0;
    repeat (3 * INT_LEN) begin
      @(negedge clk);
      t = t + irq;
    end
    chk(t[7:0], 8'h00);
    ldsr_host_inst.poll(6, ok);
    chk({7'h00, ok}, 8'h01);
    ldsr_host_inst.wr(3'h4, 8'h1e);
    wait_irq;
    close_out;
  end
endmodule // lock_detector_status_readout_tb
